/* File: asr_pkg.sv */
/*
 Package for the async SRAM host controller: timing figures,
 derived cycle counts, state encoding and request carrier.
 Assumes a 125 MHz system clock.
*/
package asr_pkg;
    localparam int CLK_PERIOD_PS = 8000;
    // Figures in ns, scaled to ps
    localparam int T_RC_PS = 45000;   // Read cycle time
    localparam int T_AA_PS = 45000;   // Address to data valid
    localparam int T_PWE_PS = 35000;  // Strobe width and address setup
    localparam int T_SD_PS = 25000;   // Data setup to write end
    localparam int T_HZWE_PS = 18000; // Strobe low to outputs floating
    localparam int T_HZOE_PS = 18000; // Output drive off to floating
    localparam int T_WC_PS = 45000;   // Write cycle time
    // Least times round up
    localparam int RD_CYC = (T_AA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WR_MIN_PS = (T_PWE_PS > T_HZWE_PS + T_SD_PS) ?
        T_PWE_PS : T_HZWE_PS + T_SD_PS;
    localparam int WR_CYC = (WR_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TURN_CYC = (T_HZOE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RC_CYC = (T_RC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WC_CYC = (T_WC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 4;
    localparam logic [1:0] LANES_NONE = 2'h3;

    typedef enum logic [2:0] {
        ASR_IDLE = 3'b000,
        ASR_READ = 3'b001,
        ASR_WRITE = 3'b010,
        ASR_TURN = 3'b011,
        ASR_REST = 3'b100
    } asr_state_t;

    typedef struct packed {
        logic [19:0] addr;
        logic [15:0] wdata;
        logic [1:0] lane_n;  // Bit 1 upper lane, bit 0 lower lane
        logic write;
    } asr_req_t;
endpackage

/* File: asr_ctrl.sv */
/*
 Host-side controller for a 16-bit asynchronous SRAM with byte lanes.
 Accepts one request at a time and sequences the memory pins.
 Assumes the memory is the only other driver of the data pins.
*/
`timescale 1ns/10ps
// How it works
// - Write: select low, select high, strobe low, lanes pick stored bytes.
// - Setup and hold timed to the edge ending the window.
// - Host never drives data while memory may still drive.
// - Strobe low at least turn-off plus data setup.
// - Address stable 35 ns before write end, none before start.
// - Address held until write window closed.
// - Write data present 25 ns before write end.
// - Write data held to the terminating edge.
// - Lane enables active 35 ns before write end.
module asr_ctrl #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire asr_pkg::asr_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_data,
    output logic [ADDR_W-1:0] mem_addr,
    output logic chip_sel_n,
    output logic chip_sel_hi,
    output logic write_n,
    output logic out_en_n,
    output logic upper_lane_n,
    output logic lower_lane_n,
    input wire logic [DATA_W-1:0] mem_dq_in,
    output logic [DATA_W-1:0] mem_dq_out,
    output logic mem_dq_oe
);
    // Refuse widths and counts that the sequencer cannot serve
    localparam bit CNT_BAD =
        (asr_pkg::RD_CYC + 2 >= 2 ** asr_pkg::CNT_W) ||
        (asr_pkg::WR_CYC + 2 < asr_pkg::WC_CYC) ||
        (asr_pkg::RD_CYC + asr_pkg::TURN_CYC < asr_pkg::RC_CYC);
    if (ADDR_W != 20 || DATA_W != 16) begin : g_bad_width
        $error("asr_ctrl serves only 20-bit address, 16-bit data");
    end
    if (CNT_BAD) begin : g_bad_cnt
        $error("asr_ctrl counters cannot meet the cycle times");
    end

    asr_pkg::asr_state_t state_q, state_d;
    logic [asr_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
    logic [DATA_W-1:0] rdata_q;
    logic rvalid_q;
    logic cs_n_q, cs_hi_q, we_n_q, oe_n_q, oe_q;
    logic [1:0] lane_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic ready_q;

    // Named decode of the current step
    wire logic take = req_valid && ready_q;
    wire logic lanes_on = (req.lane_n != asr_pkg::LANES_NONE);
    wire logic cnt_done = (cnt_q == '0);
    localparam logic [asr_pkg::CNT_W-1:0] RD_N =
        asr_pkg::CNT_W'(asr_pkg::RD_CYC + 2);  // Two for pin sync
    localparam logic [asr_pkg::CNT_W-1:0] WR_N =
        asr_pkg::CNT_W'(asr_pkg::WR_CYC - 1);
    localparam logic [asr_pkg::CNT_W-1:0] TURN_N =
        asr_pkg::CNT_W'(asr_pkg::TURN_CYC - 1);
    localparam logic [asr_pkg::CNT_W-1:0] REST_N = asr_pkg::CNT_W'(0);
    // Lane mask used when capturing read data per byte
    wire logic [DATA_W-1:0] lane_mask =
        {{8{~lane_q[1]}}, {8{~lane_q[0]}}};

    // Next-state sequencing
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
        case (state_q)
            asr_pkg::ASR_IDLE: begin
                if (take && lanes_on) begin
                    state_d = req.write ? asr_pkg::ASR_WRITE
                                        : asr_pkg::ASR_READ;
                    cnt_d = req.write ? WR_N : RD_N;
                end
            end
            asr_pkg::ASR_READ: begin
                if (cnt_done) begin
                    state_d = asr_pkg::ASR_TURN;
                    cnt_d = TURN_N;
                end
            end
            asr_pkg::ASR_WRITE: begin
                if (cnt_done) begin
                    state_d = asr_pkg::ASR_REST;
                    cnt_d = REST_N;
                end
            end
            asr_pkg::ASR_TURN,
            asr_pkg::ASR_REST: begin
                if (cnt_done)
                    state_d = asr_pkg::ASR_IDLE;
            end
            default: state_d = asr_pkg::ASR_IDLE;
        endcase
    end

    // Data pins pass two flops before use
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
        end else if (clk_en) begin
            dq_s1_q <= mem_dq_in;
            dq_s2_q <= dq_s1_q;
        end
    end

    // State and counter
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= asr_pkg::ASR_IDLE;
            cnt_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Latch request; address and data held for whole access
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
            wdata_q <= '0;
            lane_q <= asr_pkg::LANES_NONE;
        end else if (clk_en && take && lanes_on) begin
            addr_q <= req.addr;
            wdata_q <= req.wdata;
            lane_q <= req.lane_n;
        end
    end

    // Pin controls: one window; selects and the active strobe open and close together, lanes stay as latched
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_n_q <= 1'b1;
            cs_hi_q <= 1'b0;
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            oe_q <= 1'b0;
        end else if (clk_en) begin
            cs_n_q <= !(state_d == asr_pkg::ASR_READ ||
                        state_d == asr_pkg::ASR_WRITE);
            cs_hi_q <= (state_d == asr_pkg::ASR_READ ||
                        state_d == asr_pkg::ASR_WRITE);
            we_n_q <= !(state_d == asr_pkg::ASR_WRITE);
            oe_n_q <= !(state_d == asr_pkg::ASR_READ);
            // Drive only after the read turnaround is over
            oe_q <= (state_d == asr_pkg::ASR_WRITE);
        end
    end

    // Read capture on the final read cycle, masked per lane
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
            ready_q <= 1'b0;
        end else if (clk_en) begin
            rvalid_q <= (state_q == asr_pkg::ASR_READ) && cnt_done;
            if ((state_q == asr_pkg::ASR_READ) && cnt_done)
                rdata_q <= dq_s2_q & lane_mask;
            ready_q <= (state_d == asr_pkg::ASR_IDLE) && !take;
        end
    end

    assign req_ready = ready_q;
    assign rsp_valid = rvalid_q;
    assign rsp_data = rdata_q;
    assign mem_addr = addr_q;
    assign chip_sel_n = cs_n_q;
    assign chip_sel_hi = cs_hi_q;
    assign write_n = we_n_q;
    assign out_en_n = oe_n_q;
    assign upper_lane_n = lane_q[1];
    assign lower_lane_n = lane_q[0];
    assign mem_dq_out = wdata_q;
    assign mem_dq_oe = oe_q;

    // Strobe low must last the full write width
    logic [asr_pkg::CNT_W-1:0] wlen_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            wlen_q <= '0;
        else if (clk_en)
            wlen_q <= write_n ? '0 : wlen_q + 1'b1;
    end

    property p_wr_width;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(write_n) |-> $past(wlen_q) >= (WR_N);
    endproperty
    a_wr_width: assert property (p_wr_width)
        else $error("write strobe too short");

    property p_wr_sel;
        @(posedge sys_clk) disable iff (!rst_n)
        !write_n |-> !chip_sel_n && chip_sel_hi &&
            !(upper_lane_n && lower_lane_n);
    endproperty
    a_wr_sel: assert property (p_wr_sel)
        else $error("write without full select");

    property p_no_clash;
        @(posedge sys_clk) disable iff (!rst_n)
        mem_dq_oe |-> out_en_n && !write_n;
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("host drives while memory may drive");

    property p_turn;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(out_en_n) |-> !mem_dq_oe [*3];
    endproperty
    a_turn: assert property (p_turn)
        else $error("turnaround too short");

    property p_addr_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        !write_n && $past(!write_n) |-> $stable(mem_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved in write");

    property p_data_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        !write_n && $past(!write_n) |-> $stable(mem_dq_out) && mem_dq_oe;
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("write data moved in write");

    property p_lane_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        !chip_sel_n && $past(!chip_sel_n) |->
            $stable({upper_lane_n, lower_lane_n});
    endproperty
    a_lane_hold: assert property (p_lane_hold)
        else $error("lanes changed in access");

    sequence s_rd_open;
        $fell(out_en_n);
    endsequence
    property p_rd_len;
        @(posedge sys_clk) disable iff (!rst_n)
        s_rd_open |-> !out_en_n [*6];
    endproperty
    a_rd_len: assert property (p_rd_len)
        else $error("read cycle too short");
endmodule // asr_ctrl

/* File: asr_sram_model.sv */
/*
 Behavioural model of the 16-bit byte-lane static memory for the bench.
 Assumes the bench resolves the shared data wire and reads viol.
*/
`timescale 1ns/10ps
module asr_sram_model #(
    parameter int ACC_NS = 45
) (
    input wire logic [19:0] mem_addr,
    input wire logic chip_sel_n,
    input wire logic chip_sel_hi,
    input wire logic write_n,
    input wire logic out_en_n,
    input wire logic upper_lane_n,
    input wire logic lower_lane_n,
    input wire logic [15:0] dq_bus,
    output logic [15:0] dq_val,
    output logic [1:0] dq_en,
    output logic viol
);
    logic [15:0] mem [logic [19:0]];
    logic [15:0] junk = 16'h00ff;
    logic [15:0] word;
    logic [15:0] w;
    logic ok;
    realtime t_w, t_a, t_d;
    wire [19:0] a_late;
    wire rd_late;
    wire [38:0] held;
    // Selected only with both selects and at least one lane
    wire lanes_on = !(upper_lane_n && lower_lane_n);
    wire sel = !chip_sel_n && chip_sel_hi && lanes_on;
    wire rd = sel && write_n && !out_en_n;
    wire wr = sel && !write_n;
    assign #(ACC_NS) a_late = mem_addr;
    assign #22 rd_late = rd;
    // Delayed copy, so the closing edge still sees the held values
    assign #1 held = {upper_lane_n, lower_lane_n, out_en_n, mem_addr, dq_bus};
    initial viol = 1'b0;
    // Released lines wander instead of keeping the last value
    always #3 junk = {junk[14:0], ~junk[15]};
    always @(posedge wr) t_w = $realtime;
    always @(held[35:16]) t_a = $realtime;
    always @(held[15:0]) t_d = $realtime;
    // Drivers follow the read at once, data only once access time is met
    always @* begin
        word = mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
        dq_en = {rd && !upper_lane_n, rd && !lower_lane_n};
        ok = rd_late && a_late == mem_addr;
        dq_val = junk;
        if (ok && dq_en[1]) dq_val[15:8] = word[15:8];
        if (ok && dq_en[0]) dq_val[7:0] = word[7:0];
    end
    // Store enabled lanes when the window closes, then judge its timing
    // Zero-width pulses from skewed pin updates store nothing
    always @(negedge wr) if ($realtime > t_w) begin
        w = mem.exists(held[35:16]) ? mem[held[35:16]] : 16'h0000;
        if (!held[38]) w[15:8] = held[15:8];
        if (!held[37]) w[7:0] = held[7:0];
        mem[held[35:16]] = w;
        if ($realtime - t_w < (held[36] ? 35.0 : 43.0)) viol = 1'b1;
        if ($realtime - t_a < 34.0) viol = 1'b1;
        if ($realtime - t_d < 24.0) viol = 1'b1;
    end
endmodule // asr_sram_model

/* File: asr_ctrl_tb.sv */
/*
 Self-checking bench: asr_ctrl driving the memory model.
 Assumes asr_pkg and asr_sram_model are compiled first.
*/
`timescale 1ns/10ps
module asr_ctrl_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic req_valid = 1'b0;
    asr_pkg::asr_req_t req = '0;
    logic req_ready, rsp_valid, mem_dq_oe, viol;
    logic chip_sel_n, chip_sel_hi, write_n, out_en_n;
    logic upper_lane_n, lower_lane_n;
    logic [15:0] rsp_data, mem_dq_out, dq_val, dq_bus;
    logic [19:0] mem_addr;
    logic [1:0] dq_en;
    logic [15:0] rnd = 16'h4642;
    logic [15:0] ce_s = 16'h4642;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int ref_mem [int];

    // Shared data wire; two drivers at once show as unknown
    assign dq_bus = (mem_dq_oe && |dq_en) ? 16'hxxxx :
        mem_dq_oe ? mem_dq_out : dq_val;

    asr_ctrl dut (.sys_clk, .rst_n, .clk_en, .req_valid, .req, .req_ready,
        .rsp_valid, .rsp_data, .mem_addr, .chip_sel_n, .chip_sel_hi,
        .write_n, .out_en_n, .upper_lane_n, .lower_lane_n,
        .mem_dq_in(dq_bus), .mem_dq_out, .mem_dq_oe);

    asr_sram_model #(.ACC_NS(45)) mem_model (.mem_addr, .chip_sel_n,
        .chip_sel_hi, .write_n, .out_en_n, .upper_lane_n, .lower_lane_n,
        .dq_bus, .dq_val, .dq_en, .viol);

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic cmp_word(input string nm, input logic [15:0] e,
                            input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask

    task automatic summarize();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Random clock-enable gaps, watchdog and pin watch
    always @(negedge sys_clk) begin
        ce_s <= lfsr(ce_s);
        clk_en <= ce_s[2:0] != 3'h0;
        cyc <= cyc + 1;
        if (rst_n) cmp_bit("drive_clash", 1'b0, mem_dq_oe && |dq_en);
        if (rst_n && !write_n)
            cmp_bit("write_sel", 1'b1, !chip_sel_n && chip_sel_hi);
        if (cyc > 20000) begin
            error_cnt++;
            summarize();
        end
    end

    // One request through ready; reads checked against the reference
    task automatic do_op(input logic wr, input logic [19:0] a,
                         input logic [15:0] d, input logic [1:0] ln);
        int k;
        int e;
        e = ref_mem.exists(a) ? ref_mem[a] : 0;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req = {a, d, ln, wr};
        #1;
        k = 0;
        while (!(req_ready && clk_en) && k < 60) begin
            @(negedge sys_clk);
            #1;
            k++;
        end
        if (k == 60) error_cnt++;
        @(negedge sys_clk);
        req_valid = 1'b0;
        if (ln == 2'h3) return;
        if (wr) begin
            if (!ln[1]) e = (e & 32'h00ff) | (d & 16'hff00);
            if (!ln[0]) e = (e & 32'hff00) | (d & 16'h00ff);
            ref_mem[a] = e;
            return;
        end
        if (ln[1]) e = e & 32'h00ff;
        if (ln[0]) e = e & 32'hff00;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 40) begin
            @(negedge sys_clk);
            k++;
        end
        cmp_bit("read_valid", 1'b1, rsp_valid);
        cmp_word("read_word", e[15:0], rsp_data);
    endtask

    initial begin
        repeat (5) @(negedge sys_clk);
        cmp_bit("reset_drive", 1'b0, mem_dq_oe);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        cmp_bit("ready_after_reset", 1'b1, req_ready);
        // Every lane code written over a full word, read whole and by lane
        for (int i = 0; i < 4; i++) begin
            do_op(1'b1, 20'h80005, 16'h1234, 2'h0);
            do_op(1'b1, 20'h80005, 16'habcd, i[1:0]);
            do_op(1'b0, 20'h80005, 16'h0000, 2'h0);
            do_op(1'b0, 20'h80005, 16'h0000, i[1:0]);
        end
        // Random mix over a few addresses, half just above the middle of the range
        for (int i = 0; i < 60; i++) begin
            rnd = lfsr(rnd);
            do_op(rnd[10], {rnd[15], 16'h0000, rnd[2:0]}, lfsr(rnd),
                  rnd[12:11]);
        end
        cmp_bit("window_timing", 1'b0, viol);
        summarize();
    end
endmodule // asr_ctrl_tb
